// ==== hdl/mso_map.vh ====
// Offsets, field positions, reset values and timing counts of the mode and over-voltage block
`ifndef MSO_MAP_VH
`define MSO_MAP_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define MSO_REG_COMMAND      8'h00
`define MSO_REG_STATUS_FIRST 8'h01
`define MSO_REG_STATUS_SECOND 8'h02
`define MSO_REG_IRQ_STATUS   8'h03
`define MSO_REG_IRQ_MASK     8'h04
`define MSO_REG_MODE_INFO    8'h05

// ----------------------------------------
// Field positions
// ----------------------------------------
`define MSO_CMD_THR_LSB      0
`define MSO_CMD_THR_MSB      1
`define MSO_ST1_OVERVOLT     0
`define MSO_ST2_UNDERVOLT    0
`define MSO_IRQ_OVERVOLT     0
`define MSO_IRQ_UNDERVOLT    1
`define MSO_IRQ_HOST_READY   2
`define MSO_INFO_SERIAL      0
`define MSO_INFO_RUN         1
`define MSO_INFO_BOOST       2
`define MSO_INFO_HOST_READY  3
`define MSO_INFO_BUS_RESUME  4

// ----------------------------------------
// Threshold codes
// ----------------------------------------
`define MSO_THR_31V4         2'h0
`define MSO_THR_24V          2'h1
`define MSO_THR_20V          2'h2
`define MSO_THR_RSVD         2'h3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define MSO_RST_COMMAND      8'h00
`define MSO_RST_IRQ_MASK     3'h0

// ----------------------------------------
// Timing
// ----------------------------------------
`define MSO_CLK_HZ           100000000
`define MSO_STARTUP_WAIT_MS  1
`define MSO_BUS_RESUME_US    5

`endif

// ==== hdl/mso_ovp.v ====
// Output over-voltage threshold selection and boost auto-restart
`timescale 1ns/100ps
`include "mso_map.vh"
module mso_ovp (
    // Clock and reset
    input  wire       clk_in,
    input  wire       rst_n_in,
    // Control
    input  wire       run_in,
    input  wire       serial_mode_in,
    input  wire [1:0] code_in,
    // Comparators, already synchronised
    input  wire       trip_in,
    input  wire       recover_in,
    // Results
    output reg  [1:0] thr_sel_out,
    output reg        boost_on_out,
    output reg        trip_evt_out
);

    reg tripped;

    // ----------------------------------------
    // Threshold decode
    // ----------------------------------------
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            thr_sel_out <= `MSO_THR_31V4;
        end else if (!serial_mode_in) begin
            thr_sel_out <= `MSO_THR_31V4; // RQ15
        end else if (code_in == `MSO_THR_RSVD) begin
            thr_sel_out <= `MSO_THR_31V4; // RQ17
        end else begin
            thr_sel_out <= code_in; // RQ14
        end
    end

    // ----------------------------------------
    // Trip latch and restart
    // ----------------------------------------
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tripped      <= 1'b0;
            boost_on_out <= 1'b0;
            trip_evt_out <= 1'b0;
        end else begin
            trip_evt_out <= run_in && trip_in && !tripped;
            if (!run_in) begin
                tripped <= 1'b0;
            end else if (trip_in) begin
                tripped <= 1'b1; // RQ12
            end else if (recover_in) begin
                // Recovery level carries the hysteresis below the trip point
                tripped <= 1'b0; // RQ13
            end
            boost_on_out <= run_in && !trip_in && !(tripped && !recover_in); // RQ12
        end
    end

endmodule

// ==== hdl/mso_sync.v ====
// Two-flop synchroniser bank for pin-level inputs
`timescale 1ns/100ps
module mso_sync #(
    parameter WIDTH = 10
) (
    // Clock and reset
    input  wire             clk_in,
    input  wire             rst_n_in,
    // Data
    input  wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] meta;
    reg [WIDTH-1:0] stable;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            always @(posedge clk_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    meta[i]   <= 1'b0;
                    stable[i] <= 1'b0;
                end else begin
                    meta[i]   <= async_in[i];
                    stable[i] <= meta[i];
                end
            end
        end
    endgenerate

    assign sync_out = stable;

endmodule

// ==== hdl/mso_top.v ====
// Start-up mode selection, sequencing, over-voltage status and register port
`timescale 1ns/100ps
`include "mso_map.vh"
// Contract
// RQ1 - I/O supply high at start-up selects serial mode, low selects pin mode.
// RQ2 - System settles the I/O supply pin before supply and enable both assert.
// RQ3 - System never leaves the I/O supply pin floating.
// RQ4 - Nothing runs unless input supply and enable are both high.
// RQ5 - Host waits 1 ms after supply and enable before its first command.
// RQ6 - Register values survive an I/O supply sag.
// RQ7 - Host waits 5 us of stable I/O supply before resuming transfers.
// RQ8 - In serial mode the two bus pins are clock and data.
// RQ9 - In pin mode the two bus pins pick one of four trim settings.
// RQ10 - Dimming input is accepted at any time, whatever the other inputs do.
// RQ11 - Under-voltage lockout shuts the device down at once.
// RQ12 - Over-voltage trip sets the status flag and stops the boost.
// RQ13 - Boost restarts by itself once output falls below threshold with hysteresis.
// RQ14 - Threshold code 00, 01, 10 select 31.4 V, 24 V, 20 V.
// RQ15 - Pin mode fixes the threshold at 31.4 V.
// RQ16 - Reading a status register clears its fault flags.
// RQ17 - Reserved code 11 applies the highest threshold.
module mso_top #(
    parameter STARTUP_CYCLES = (`MSO_STARTUP_WAIT_MS * `MSO_CLK_HZ) / 1000
) (
    // Clock and reset
    input  wire       REF_CLK_IN,
    input  wire       RST_N_IN,
    // Supply and enable
    input  wire       INPUT_SUPPLY_IN,
    input  wire       ENABLE_IN,
    input  wire       INPUT_UNDERVOLT_LOCKOUT_IN,
    input  wire       IO_SUPPLY_PIN_IN,
    input  wire       IO_SUPPLY_OK_IN,
    // Bus pins and dimming
    input  wire       SCL_IN,
    input  wire       SDA_IN,
    input  wire       PWM_IN,
    // Over-voltage comparators
    input  wire       OVP_TRIP_IN,
    input  wire       OVP_RECOVER_IN,
    // Register port
    input  wire [7:0] REG_ADDR_IN,
    input  wire [7:0] REG_WR_DATA_IN,
    input  wire       REG_WR_IN,
    input  wire       REG_RD_IN,
    output reg  [7:0] REG_RD_DATA_OUT,
    // Sequencing and mode
    output reg        REGULATOR_EN_OUT,
    output reg        OPERATIONAL_OUT,
    output reg        SERIAL_MODE_OUT,
    output reg        HOST_READY_OUT,
    output reg        BUS_RESUME_OUT,
    // Serial bus routing
    output reg        I2C_SCL_OUT,
    output reg        I2C_SDA_OUT,
    // Pin-mode trim and dimming
    output reg  [1:0] MAX_CURRENT_TRIM_SELECT_OUT,
    output reg        PWM_OUT,
    // Over-voltage control
    output reg  [1:0] OVERVOLT_THRESHOLD_SEL_OUT,
    output reg        BOOST_EN_OUT,
    // Interrupt
    output reg        IRQ_OUT
);

    // ----------------------------------------
    // Constants
    // ----------------------------------------
    localparam [1:0]  ST_OFF  = 2'h0;
    localparam [1:0]  ST_RAMP = 2'h1;
    localparam [1:0]  ST_RUN  = 2'h2;
    localparam        STARTUP_INT  = STARTUP_CYCLES - 1;
    localparam        RESUME_INT   = (`MSO_BUS_RESUME_US * `MSO_CLK_HZ) / 1000000 - 1;
    // Counters are sized for the defaults; the cut is on purpose
    localparam [16:0] STARTUP_LAST = STARTUP_INT[16:0];
    localparam [9:0]  RESUME_LAST  = RESUME_INT[9:0];

    // ----------------------------------------
    // Synchronised pins
    // ----------------------------------------
    wire [9:0] pin_sync;
    wire       s_supply;
    wire       s_enable;
    wire       s_input_undervolt_lockout;
    wire       s_io_pin;
    wire       s_io_ok;
    wire       s_scl;
    wire       s_sda;
    wire       s_pwm;
    wire       s_trip;
    wire       s_recover;

    mso_sync #(
        .WIDTH(10)
    ) u_sync (
        .clk_in   (REF_CLK_IN),
        .rst_n_in (RST_N_IN),
        .async_in ({OVP_RECOVER_IN, OVP_TRIP_IN, PWM_IN, SDA_IN, SCL_IN,
                    IO_SUPPLY_OK_IN, IO_SUPPLY_PIN_IN, INPUT_UNDERVOLT_LOCKOUT_IN,
                    ENABLE_IN, INPUT_SUPPLY_IN}),
        .sync_out (pin_sync)
    );

    assign s_supply  = pin_sync[0];
    assign s_enable  = pin_sync[1];
    assign s_input_undervolt_lockout    = pin_sync[2];
    assign s_io_pin  = pin_sync[3];
    assign s_io_ok   = pin_sync[4];
    assign s_scl     = pin_sync[5];
    assign s_sda     = pin_sync[6];
    assign s_pwm     = pin_sync[7];
    assign s_trip    = pin_sync[8];
    assign s_recover = pin_sync[9];

    // ----------------------------------------
    // State
    // ----------------------------------------
    reg  [1:0]  state;
    reg  [1:0]  next_state;
    reg  [16:0] startup_cnt;
    reg  [9:0]  resume_cnt;
    reg         serial_mode;
    reg  [7:0]  command;
    reg         overvolt_flag;
    reg         undervolt_flag;
    reg  [2:0]  irq_status;
    reg  [2:0]  irq_mask;
    reg         input_undervolt_lockout_prev;
    wire        power_good;
    wire        running;
    wire [1:0]  thr_sel;
    wire        boost_on;
    wire        trip_evt;
    wire        input_undervolt_lockout_evt;
    wire        ready_evt;
    wire        rd_st1;
    wire        rd_st2;
    wire        wr_irq;
    wire [2:0]  irq_set;

    // Supply, enable and no lockout are all needed to run
    assign power_good = s_supply && s_enable && !s_input_undervolt_lockout; // RQ4 RQ11
    assign running    = (state == ST_RAMP) || (state == ST_RUN);
    assign input_undervolt_lockout_evt   = s_input_undervolt_lockout && !input_undervolt_lockout_prev;
    assign ready_evt  = (state == ST_RAMP) && power_good && (startup_cnt == STARTUP_LAST);
    assign rd_st1     = REG_RD_IN && (REG_ADDR_IN == `MSO_REG_STATUS_FIRST);
    assign rd_st2     = REG_RD_IN && (REG_ADDR_IN == `MSO_REG_STATUS_SECOND);
    assign wr_irq     = REG_WR_IN && (REG_ADDR_IN == `MSO_REG_IRQ_STATUS);
    assign irq_set    = {ready_evt, input_undervolt_lockout_evt, trip_evt};

    // ----------------------------------------
    // Power sequencing
    // ----------------------------------------
    always @* begin
        next_state = state;
        case (state)
            ST_OFF: begin
                if (power_good) begin
                    next_state = ST_RAMP; // RQ4
                end
            end
            ST_RAMP: begin
                if (!power_good) begin
                    next_state = ST_OFF; // RQ11
                end else if (startup_cnt == STARTUP_LAST) begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (!power_good) begin
                    next_state = ST_OFF; // RQ11
                end
            end
            default: begin
                next_state = ST_OFF;
            end
        endcase
    end

    always @(posedge REF_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            state       <= ST_OFF;
            startup_cnt <= 17'h00000;
            serial_mode <= 1'b0;
            input_undervolt_lockout_prev   <= 1'b0;
        end else begin
            state     <= next_state;
            input_undervolt_lockout_prev <= s_input_undervolt_lockout;
            if (state == ST_OFF && power_good) begin
                // Mode is sampled once, as supply and enable come up
                serial_mode <= s_io_pin; // RQ1
            end
            if (state == ST_RAMP && power_good && startup_cnt != STARTUP_LAST) begin
                startup_cnt <= startup_cnt + 17'h00001; // RQ5
            end else if (state != ST_RAMP) begin
                startup_cnt <= 17'h00000;
            end
        end
    end

    // ----------------------------------------
    // I/O supply stability
    // ----------------------------------------
    // Only a status hint; transfers are paced by the host
    always @(posedge REF_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            resume_cnt     <= 10'h000;
            BUS_RESUME_OUT <= 1'b0;
        end else begin
            if (!s_io_ok || !running || !serial_mode) begin
                resume_cnt     <= 10'h000;
                BUS_RESUME_OUT <= 1'b0;
            end else if (resume_cnt != RESUME_LAST) begin
                resume_cnt <= resume_cnt + 10'h001; // RQ7
            end else begin
                BUS_RESUME_OUT <= 1'b1; // RQ7
            end
        end
    end

    // ----------------------------------------
    // Over-voltage control
    // ----------------------------------------
    mso_ovp u_ovp (
        .clk_in         (REF_CLK_IN),
        .rst_n_in       (RST_N_IN),
        .run_in         (running),
        .serial_mode_in (serial_mode),
        .code_in        (command[`MSO_CMD_THR_MSB:`MSO_CMD_THR_LSB]),
        .trip_in        (s_trip),
        .recover_in     (s_recover),
        .thr_sel_out    (thr_sel),
        .boost_on_out   (boost_on),
        .trip_evt_out   (trip_evt)
    );

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    // Cleared only by reset or while powered off; an I/O supply sag does not touch them
    always @(posedge REF_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            command  <= `MSO_RST_COMMAND;
            irq_mask <= `MSO_RST_IRQ_MASK;
        end else if (state == ST_OFF) begin
            command  <= `MSO_RST_COMMAND;
            irq_mask <= `MSO_RST_IRQ_MASK;
        end else if (REG_WR_IN && serial_mode) begin // RQ6
            if (REG_ADDR_IN == `MSO_REG_COMMAND) begin
                command <= REG_WR_DATA_IN;
            end
            if (REG_ADDR_IN == `MSO_REG_IRQ_MASK) begin
                irq_mask <= REG_WR_DATA_IN[2:0];
            end
        end
    end

    // Set wins over clear-on-read
    always @(posedge REF_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            overvolt_flag  <= 1'b0;
            undervolt_flag <= 1'b0;
        end else begin
            if (trip_evt) begin
                overvolt_flag <= 1'b1; // RQ12
            end else if (rd_st1) begin
                overvolt_flag <= 1'b0; // RQ16
            end
            if (input_undervolt_lockout_evt) begin
                undervolt_flag <= 1'b1;
            end else if (rd_st2) begin
                undervolt_flag <= 1'b0; // RQ16
            end
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_irq
            always @(posedge REF_CLK_IN or negedge RST_N_IN) begin
                if (!RST_N_IN) begin
                    irq_status[gi] <= 1'b0;
                end else if (irq_set[gi]) begin
                    irq_status[gi] <= 1'b1;
                end else if (wr_irq && REG_WR_DATA_IN[gi]) begin
                    irq_status[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // Read port
    // ----------------------------------------
    always @(posedge REF_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            REG_RD_DATA_OUT <= 8'h00;
        end else if (REG_RD_IN) begin
            case (REG_ADDR_IN)
                `MSO_REG_COMMAND: begin
                    REG_RD_DATA_OUT <= command;
                end
                `MSO_REG_STATUS_FIRST: begin
                    REG_RD_DATA_OUT <= {7'h00, overvolt_flag};
                end
                `MSO_REG_STATUS_SECOND: begin
                    REG_RD_DATA_OUT <= {7'h00, undervolt_flag};
                end
                `MSO_REG_IRQ_STATUS: begin
                    REG_RD_DATA_OUT <= {5'h00, irq_status};
                end
                `MSO_REG_IRQ_MASK: begin
                    REG_RD_DATA_OUT <= {5'h00, irq_mask};
                end
                `MSO_REG_MODE_INFO: begin
                    REG_RD_DATA_OUT <= {3'h0, BUS_RESUME_OUT, HOST_READY_OUT,
                                        boost_on, running, serial_mode};
                end
                default: begin
                    REG_RD_DATA_OUT <= 8'h00;
                end
            endcase
        end else begin
            REG_RD_DATA_OUT <= 8'h00;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    always @(posedge REF_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            REGULATOR_EN_OUT            <= 1'b0;
            OPERATIONAL_OUT             <= 1'b0;
            SERIAL_MODE_OUT             <= 1'b0;
            HOST_READY_OUT              <= 1'b0;
            I2C_SCL_OUT                 <= 1'b1;
            I2C_SDA_OUT                 <= 1'b1;
            MAX_CURRENT_TRIM_SELECT_OUT <= 2'h0;
            PWM_OUT                     <= 1'b0;
            OVERVOLT_THRESHOLD_SEL_OUT  <= `MSO_THR_31V4;
            BOOST_EN_OUT                <= 1'b0;
            IRQ_OUT                     <= 1'b0;
        end else begin
            REGULATOR_EN_OUT <= (next_state != ST_OFF); // RQ4
            OPERATIONAL_OUT  <= (next_state == ST_RUN); // RQ4
            SERIAL_MODE_OUT  <= serial_mode; // RQ1
            HOST_READY_OUT   <= serial_mode && (next_state == ST_RUN); // RQ5
            if (running && serial_mode) begin
                I2C_SCL_OUT <= s_scl; // RQ8
                I2C_SDA_OUT <= s_sda; // RQ8
            end else begin
                I2C_SCL_OUT <= 1'b1;
                I2C_SDA_OUT <= 1'b1;
            end
            if (running && !serial_mode) begin
                MAX_CURRENT_TRIM_SELECT_OUT <= {s_scl, s_sda}; // RQ9
            end
            // No gating at all: dimming passes in every state
            PWM_OUT                    <= s_pwm; // RQ10
            OVERVOLT_THRESHOLD_SEL_OUT <= thr_sel;
            BOOST_EN_OUT               <= boost_on && power_good; // RQ11 RQ12
            IRQ_OUT                    <= |(irq_status & irq_mask);
        end
    end

endmodule

// ==== testbench/mso_top_monitor.sv ====
// Concurrent checks on the ports of the mode and over-voltage block
`timescale 1ns/100ps
module mso_top_monitor (
    // Clock and reset
    input wire       REF_CLK_IN,
    input wire       RST_N_IN,
    // Watched inputs
    input wire       INPUT_SUPPLY_IN,
    input wire       ENABLE_IN,
    input wire       INPUT_UNDERVOLT_LOCKOUT_IN,
    input wire       SCL_IN,
    input wire       SDA_IN,
    input wire       PWM_IN,
    input wire       OVP_TRIP_IN,
    input wire       REG_RD_IN,
    // Watched outputs
    input wire [7:0] REG_RD_DATA_OUT,
    input wire       REGULATOR_EN_OUT,
    input wire       OPERATIONAL_OUT,
    input wire       SERIAL_MODE_OUT,
    input wire       HOST_READY_OUT,
    input wire       I2C_SCL_OUT,
    input wire       I2C_SDA_OUT,
    input wire [1:0] MAX_CURRENT_TRIM_SELECT_OUT,
    input wire       PWM_OUT,
    input wire [1:0] OVERVOLT_THRESHOLD_SEL_OUT,
    input wire       BOOST_EN_OUT
);
    default clocking @(posedge REF_CLK_IN); endclocking
    default disable iff (!RST_N_IN);

    // ----------------------------------------
    // Sequences
    // ----------------------------------------
    // Running long enough that the pin synchronisers hold live values
    sequence s_live;
        OPERATIONAL_OUT && $past(OPERATIONAL_OUT, 3);
    endsequence
    sequence s_trip;
        OVP_TRIP_IN && OPERATIONAL_OUT;
    endsequence

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_reg_en_power: assert property (REGULATOR_EN_OUT |->
        $past(INPUT_SUPPLY_IN && ENABLE_IN && !INPUT_UNDERVOLT_LOCKOUT_IN, 3))
        else $error("regulator on without supply and enable");
    a_lockout_stops: assert property (INPUT_UNDERVOLT_LOCKOUT_IN |->
        ##3 (!REGULATOR_EN_OUT && !OPERATIONAL_OUT))
        else $error("lockout did not stop the device");
    a_host_ready_mode: assert property (HOST_READY_OUT |->
        SERIAL_MODE_OUT && OPERATIONAL_OUT)
        else $error("host ready outside serial run");
    a_i2c_route: assert property (s_live ##0 SERIAL_MODE_OUT |->
        I2C_SCL_OUT == $past(SCL_IN, 3) && I2C_SDA_OUT == $past(SDA_IN, 3))
        else $error("bus pins not routed to serial engine");
    a_trim_pins: assert property (s_live ##0 !SERIAL_MODE_OUT |->
        MAX_CURRENT_TRIM_SELECT_OUT == $past({SCL_IN, SDA_IN}, 3))
        else $error("trim select does not follow bus pins");
    a_pwm_pass: assert property ($past(RST_N_IN, 3) && $past(RST_N_IN, 2) && $past(RST_N_IN) |->
        PWM_OUT == $past(PWM_IN, 3))
        else $error("dimming input not passed through");
    a_thr_pin_fixed: assert property (OPERATIONAL_OUT && !SERIAL_MODE_OUT |->
        OVERVOLT_THRESHOLD_SEL_OUT == 2'h0)
        else $error("pin mode threshold not fixed");
    a_thr_no_rsvd: assert property (OVERVOLT_THRESHOLD_SEL_OUT != 2'h3)
        else $error("reserved threshold code applied");
    a_trip_boost_off: assert property (s_trip |-> ##[1:5] !BOOST_EN_OUT)
        else $error("boost still on after trip");
    a_rd_idle_zero: assert property (!$past(REG_RD_IN) |-> REG_RD_DATA_OUT == 8'h00)
        else $error("read data outside read slot");
endmodule

bind mso_top mso_top_monitor u_mon (.*);

// ==== testbench/mso_top_tb_top.sv ====
// Self-checking bench for the mode and over-voltage block
`timescale 1ns/100ps
module mso_top_tb_top;
    reg        ref_clk = 1'b0;
    reg        rst_n = 1'b0;
    reg        input_supply = 1'b0;
    reg        en = 1'b0;
    reg        lockout = 1'b0;
    reg        io_pin = 1'b1;
    reg        io_ok = 1'b1;
    reg        scl = 1'b1;
    reg        sda = 1'b1;
    reg        pwm = 1'b0;
    reg  [9:0] vout = 10'h064;
    reg  [7:0] addr = 8'h00;
    reg  [7:0] wdata = 8'h00;
    reg        wr = 1'b0;
    reg        rd = 1'b0;
    wire [7:0] rd_data;
    wire [1:0] trim;
    wire [1:0] thr;
    wire       trip;
    wire       recover;
    wire       reg_en;
    wire       oper;
    wire       ser;
    wire       host_rdy;
    wire       bus_res;
    wire       i2c_scl;
    wire       i2c_sda;
    wire       pwm_o;
    wire       boost;
    wire       irq;
    integer    num_errors = 0;
    integer    n_compared = 0;
    integer    i;

    always #5 ref_clk = ~ref_clk;

    mso_top #(.STARTUP_CYCLES(20)) dut (
        .REF_CLK_IN(ref_clk), .RST_N_IN(rst_n), .INPUT_SUPPLY_IN(input_supply), .ENABLE_IN(en),
        .INPUT_UNDERVOLT_LOCKOUT_IN(lockout), .IO_SUPPLY_PIN_IN(io_pin), .IO_SUPPLY_OK_IN(io_ok),
        .SCL_IN(scl), .SDA_IN(sda), .PWM_IN(pwm), .OVP_TRIP_IN(trip), .OVP_RECOVER_IN(recover),
        .REG_ADDR_IN(addr), .REG_WR_DATA_IN(wdata), .REG_WR_IN(wr), .REG_RD_IN(rd),
        .REG_RD_DATA_OUT(rd_data), .REGULATOR_EN_OUT(reg_en), .OPERATIONAL_OUT(oper),
        .SERIAL_MODE_OUT(ser), .HOST_READY_OUT(host_rdy), .BUS_RESUME_OUT(bus_res),
        .I2C_SCL_OUT(i2c_scl), .I2C_SDA_OUT(i2c_sda), .MAX_CURRENT_TRIM_SELECT_OUT(trim),
        .PWM_OUT(pwm_o), .OVERVOLT_THRESHOLD_SEL_OUT(thr), .BOOST_EN_OUT(boost), .IRQ_OUT(irq)
    );

    mso_vout_model u_vout (.thr_sel_in(thr), .vout_dv_in(vout), .trip_out(trip), .recover_out(recover));

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task chk_byte(input [7:0] got, input [7:0] exp);
        begin
            n_compared = n_compared + 1;
            if (got !== exp) begin
                num_errors = num_errors + 1;
                $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task chk_bit(input got, input exp);
        begin
            chk_byte({7'h00, got}, {7'h00, exp});
        end
    endtask
    // Lands one nanosecond past the edge so design updates have settled
    task tick(input integer n);
        begin
            repeat (n) @(posedge ref_clk);
            #1;
        end
    endtask
    task wr_reg(input [7:0] a, input [7:0] d);
        begin
            @(posedge ref_clk);
            addr <= a;
            wdata <= d;
            wr <= 1'b1;
            @(posedge ref_clk);
            wr <= 1'b0;
        end
    endtask
    task rd_reg(input [7:0] a, input [7:0] exp);
        begin
            @(posedge ref_clk);
            addr <= a;
            rd <= 1'b1;
            @(posedge ref_clk);
            rd <= 1'b0;
            #1;
            chk_byte(rd_data, exp);
        end
    endtask
    task wait_op;
        begin
            for (i = 0; i < 200 && oper !== 1'b1; i = i + 1) tick(1);
            chk_bit(oper, 1'b1);
        end
    endtask
    task results;
        begin
            $display("Comparisons %0d, mismatches %0d", n_compared, num_errors);
            if (num_errors == 0 && n_compared > 0) begin
                $display("All tests passed");
            end else begin
                $display("Some tests failed");
            end
            $finish;
        end
    endtask

    initial begin
        #100000;
        num_errors = num_errors + 1;
        results;
    end

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        tick(12);
        rst_n <= 1'b1;
        tick(10);
        chk_bit(reg_en, 1'b0);
        pwm <= 1'b1;
        tick(5);
        chk_bit(pwm_o, 1'b1);
        // I/O pin settled high long before enable
        en <= 1'b1;
        tick(6);
        chk_bit(reg_en, 1'b0);
        input_supply <= 1'b1;
        wait_op;
        chk_bit(ser, 1'b1);
        chk_bit(host_rdy, 1'b1);
        chk_bit(boost, 1'b1);
        scl <= 1'b0;
        tick(5);
        chk_byte({6'h00, i2c_scl, i2c_sda}, 8'h01);
        rd_reg(8'h0F, 8'h00);
        for (i = 0; i < 4; i = i + 1) begin
            wr_reg(8'h00, i[7:0]);
            tick(2);
            chk_byte({6'h00, thr}, (i == 3) ? 8'h00 : i[7:0]);
            rd_reg(8'h00, i[7:0]);
        end
        wr_reg(8'h00, 8'h02);
        vout <= 10'h0D2;
        tick(8);
        chk_bit(boost, 1'b0);
        chk_bit(irq, 1'b0);
        wr_reg(8'h04, 8'h01);
        tick(2);
        chk_bit(irq, 1'b1);
        vout <= 10'h0C6;
        tick(8);
        chk_bit(boost, 1'b0);
        vout <= 10'h0BE;
        tick(8);
        chk_bit(boost, 1'b1);
        rd_reg(8'h01, 8'h01);
        rd_reg(8'h01, 8'h00);
        wr_reg(8'h03, 8'h01);
        tick(2);
        chk_bit(irq, 1'b0);
        // I/O supply sag keeps registers; host reads once during the sag, then waits for resume
        io_ok <= 1'b0;
        tick(5);
        chk_bit(bus_res, 1'b0);
        rd_reg(8'h00, 8'h02);
        io_ok <= 1'b1;
        tick(450);
        chk_bit(bus_res, 1'b0);
        tick(60);
        chk_bit(bus_res, 1'b1);
        lockout <= 1'b1;
        tick(4);
        chk_bit(reg_en, 1'b0);
        chk_bit(oper, 1'b0);
        rd_reg(8'h02, 8'h01);
        rd_reg(8'h02, 8'h00);
        lockout <= 1'b0;
        en <= 1'b0;
        tick(5);
        io_pin <= 1'b0;
        tick(2);
        en <= 1'b1;
        wait_op;
        chk_bit(ser, 1'b0);
        for (i = 0; i < 4; i = i + 1) begin
            {scl, sda} <= i[1:0];
            tick(5);
            chk_byte({6'h00, trim}, i[7:0]);
        end
        wr_reg(8'h00, 8'h02);
        tick(2);
        chk_byte({6'h00, thr}, 8'h00);
        rd_reg(8'h00, 8'h00);
        results;
    end
endmodule

// ==== testbench/mso_vout_model.sv ====
// Output voltage comparator model facing the over-voltage inputs
`timescale 1ns/100ps
module mso_vout_model (
    // Threshold and output voltage in tenths of a volt
    input  wire [1:0] thr_sel_in,
    input  wire [9:0] vout_dv_in,
    // Comparators
    output wire       trip_out,
    output wire       recover_out
);
    wire [9:0] thr_dv;

    // Code 11 maps to the highest level so protection is never weakened
    assign thr_dv = (thr_sel_in == 2'h1) ? 10'h0F0 : (thr_sel_in == 2'h2) ? 10'h0C8 : 10'h13A;
    assign trip_out = vout_dv_in > thr_dv;
    // Half-volt gap keeps the boost from chattering at the threshold
    assign recover_out = vout_dv_in < (thr_dv - 10'h005);
endmodule
